// ### hdl/srdr_pkg.sv
// Constants for the delayed-release safety relay controller.
// Assumes a single 250 MHz clock and an AXI4-Lite register port.
package srdr_pkg;
    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_MHZ   = 250;
    localparam int TICK_US   = 1000;
    localparam int TICK_CYC  = CLK_MHZ * TICK_US;
    localparam int SWON_MS   = 50;
    localparam int RECOV_MS  = 300;
    localparam int CHK_MS    = 20;
    localparam int FUSE_MIN  = 1;
    localparam int FUSE_MS   = FUSE_MIN * 60000;
    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [11:0] ADDR_CTRL  = 12'h000;
    localparam logic [11:0] ADDR_DELAY = 12'h004;
    localparam logic [11:0] ADDR_STAT  = 12'h008;
    localparam logic [11:0] ADDR_ISTS  = 12'h00C;
    localparam logic [11:0] ADDR_IMSK  = 12'h010;
    localparam int CTRL_DUAL  = 0;
    localparam int CTRL_MAN   = 1;
    localparam int CTRL_NODLY = 2;
    localparam logic [2:0]  CTRL_RST  = 3'h1;
    localparam logic [15:0] DELAY_RST = 16'h03E8;
    localparam int IRQ_ACT  = 0;
    localparam int IRQ_REL  = 1;
    localparam int IRQ_FLT  = 2;
    localparam int IRQ_TRIP = 3;
    localparam int IRQ_W    = 4;
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // ------------------------------------------------------------
    // States
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_OFF  = 3'b000,
        ST_SWON = 3'b001,
        ST_ACT  = 3'b010,
        ST_REL  = 3'b011,
        ST_RECV = 3'b100,
        ST_TRIP = 3'b101
    } srdr_state_t;
endpackage

// ### hdl/srdr_relay.sv
// Delayed-release safety relay controller with AXI4-Lite registers.
// Assumes all pin inputs are synchronous to clk; relay readback high = closed.
//
// Summary of operation
// [R1] The supply lamp is lit whenever supply is present.
// [R2] The unit counts as ready only while the start loop is closed.
// [R3] While active with input closed, lamps, four contacts, aux output and on lamp are on; with zero delay the code keeps contacts and channel lamps off.
// [R4] When the input opens, aux output and on lamp drop at once.
// [R5] Contacts stay closed for the set delay after input opens, then open with the lamps.
// [R6] An independent backup timer opens contacts by twice the set delay at the latest.
// [R7] In single-channel use earth faults on start and input block activation.
// [R8] In dual-channel use earth faults, input shorts and channel bridging are detected.
// [R9] In automatic start the unit goes active as soon as the input closes; the code ignores CTRL_MAN and always needs the start loop closed.
// [R10] In manual start both input and start loop must be closed to go active.
// [R11] Bridging the cross-test terminals while active trips and opens the contacts; the code trips only in dual-channel use (CTRL_DUAL set).
// [R12] The trip clears only after the supply has been off for one minute.
// [R13] A setting disables the delay so contacts open at once.
// [R14] Relay readback is checked each cycle; a failed channel blocks reactivation.
// [R15] A switch-on delay precedes closing and a recovery time follows release.
//
// Decided for this implementation: the register addresses and register access over AXI4-Lite.
`timescale 1ns/1ps
module srdr_relay
    import srdr_pkg::*;
#(
    parameter int TICK_CYCLES = TICK_CYC,
    parameter int FUSE_TICKS  = FUSE_MS
)(
    input  wire logic        clk,
    input  wire logic        sys_rst,
    input  wire logic [11:0] s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [11:0] s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    input  wire logic        supply_present,
    input  wire logic        start_loop_terminals,
    input  wire logic        input_ch1,
    input  wire logic        input_ch2,
    input  wire logic        earth_fault_sense,
    input  wire logic        input_short_sense,
    input  wire logic        cross_test_terminal_a,
    input  wire logic        cross_test_terminal_b,
    input  wire logic [1:0]  relay_readback,
    output logic             supply_lamp,
    output logic             first_channel_lamp,
    output logic             second_channel_lamp,
    output logic [3:0]       safety_contacts,
    output logic             aux_indicator_output,
    output logic             on_lamp,
    output logic             irq
);
    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    localparam int TW = $clog2(TICK_CYCLES + 1);
    srdr_state_t        st_ff;
    srdr_state_t        nxt_st;
    logic [TW-1:0]      tick_cnt_ff;
    logic               tick_ff;
    logic [31:0]        tmr_ff;
    logic [31:0]        bk_ff;
    logic [31:0]        off_ff;
    logic [31:0]        chk_ff;
    logic [2:0]         ctrl_ff;
    logic [15:0]        delay_ff;
    logic [IRQ_W-1:0]   ists_ff;
    logic [IRQ_W-1:0]   imsk_ff;
    logic [IRQ_W-1:0]   ev;
    logic               contacts_ff;
    logic               aux_ff;
    logic               relay_flt_ff;
    logic               trip_ff;
    logic               bvalid_ff;
    logic               rvalid_ff;
    logic [1:0]         bresp_ff;
    logic [1:0]         rresp_ff;
    logic [31:0]        rdata_ff;
    logic               dual;
    logic               in_ok;
    logic               bridged;
    logic               blk;
    logic               go;
    logic               bk_force;
    logic               wr_go;

    assign dual    = ctrl_ff[CTRL_DUAL];
    assign bridged = cross_test_terminal_a & cross_test_terminal_b;
    assign in_ok   = dual ? (input_ch1 & input_ch2) : input_ch1;
    assign blk     = earth_fault_sense                              // R7
                   | (dual & (input_short_sense | bridged))         // R8
                   | relay_flt_ff | trip_ff | ~supply_present;
    assign go      = start_loop_terminals & in_ok & ~blk;          // R2
    assign bk_force = bk_ff >= {15'h0000, delay_ff, 1'b0};

    // ------------------------------------------------------------
    // Millisecond tick divider
    // ------------------------------------------------------------
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            tick_cnt_ff <= '0;
            tick_ff     <= 1'b0;
        end
        else if (tick_cnt_ff == TW'(TICK_CYCLES - 1))
        begin
            tick_cnt_ff <= '0;
            tick_ff     <= 1'b1;
        end
        else
        begin
            tick_cnt_ff <= tick_cnt_ff + 1'b1;
            tick_ff     <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // State machine
    // ------------------------------------------------------------
    always_comb
    begin
        nxt_st = st_ff;
        case (st_ff)
            ST_OFF:
                if (go)
                    nxt_st = ST_SWON;
            ST_SWON:
                if (!go)
                    nxt_st = ST_OFF;
                else if (tmr_ff >= 32'(SWON_MS))                   // R15
                    nxt_st = ST_ACT;                               // R9 R10
            ST_ACT:
                if (dual && bridged)
                    nxt_st = ST_TRIP;                              // R11
                else if (!in_ok || blk)
                    nxt_st = ctrl_ff[CTRL_NODLY] ? ST_RECV : ST_REL; // R13
            ST_REL:
                if (ctrl_ff[CTRL_NODLY] || tmr_ff >= 32'(delay_ff))
                    nxt_st = ST_RECV;                              // R5
            ST_RECV:
                if (tmr_ff >= 32'(RECOV_MS))
                    nxt_st = ST_OFF;                               // R15
            ST_TRIP:
                if (!trip_ff)
                    nxt_st = ST_OFF;                               // R12
            default:
                nxt_st = ST_OFF;
        endcase
        if (!supply_present && nxt_st != ST_TRIP)
            nxt_st = ST_OFF;
    end

    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            st_ff  <= ST_OFF;
            tmr_ff <= '0;
        end
        else
        begin
            st_ff  <= nxt_st;
            tmr_ff <= (nxt_st != st_ff) ? 32'h0000_0000 : tmr_ff + 32'(tick_ff);
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            contacts_ff <= 1'b0;
            aux_ff      <= 1'b0;
        end
        else
        begin
            contacts_ff <= (nxt_st == ST_ACT || nxt_st == ST_REL) && !bk_force; // R3 R5 R6
            aux_ff      <= nxt_st == ST_ACT;                       // R4
        end
    end

    assign supply_lamp          = supply_present;                  // R1
    assign first_channel_lamp   = contacts_ff;
    assign second_channel_lamp  = contacts_ff;
    assign safety_contacts      = {4{contacts_ff}};
    assign aux_indicator_output = aux_ff;
    assign on_lamp              = aux_ff;

    // ------------------------------------------------------------
    // Backup release timer
    // ------------------------------------------------------------
    always_ff @(posedge clk)
    begin
        if (sys_rst || !contacts_ff || in_ok)
            bk_ff <= '0;
        else if (tick_ff && !bk_force)
            bk_ff <= bk_ff + 32'h0000_0001;                         // R6
    end

    // ------------------------------------------------------------
    // Relay readback check and trip latch
    // ------------------------------------------------------------
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            chk_ff       <= '0;
            relay_flt_ff <= 1'b0;
        end
        else
        begin
            if (contacts_ff != (nxt_st == ST_ACT || nxt_st == ST_REL))
                chk_ff <= '0;
            else if (tick_ff && chk_ff < 32'(CHK_MS))
                chk_ff <= chk_ff + 32'h0000_0001;
            if (!supply_present)
                relay_flt_ff <= 1'b0;
            else if (chk_ff >= 32'(CHK_MS) && relay_readback != {2{contacts_ff}})
                relay_flt_ff <= 1'b1;                              // R14
        end
    end

    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            trip_ff <= 1'b0;
            off_ff  <= '0;
        end
        else
        begin
            if (supply_present)
                off_ff <= '0;
            else if (tick_ff && off_ff < 32'(FUSE_TICKS))
                off_ff <= off_ff + 32'h0000_0001;
            if (st_ff == ST_ACT && dual && bridged)
                trip_ff <= 1'b1;                                   // R11
            else if (off_ff >= 32'(FUSE_TICKS))
                trip_ff <= 1'b0;                                   // R12
        end
    end

    // ------------------------------------------------------------
    // Register write channel
    // ------------------------------------------------------------
    assign wr_go         = s_axi_awvalid & s_axi_wvalid & ~bvalid_ff;
    assign s_axi_awready = wr_go;
    assign s_axi_wready  = wr_go;
    assign s_axi_bvalid  = bvalid_ff;
    assign s_axi_bresp   = bresp_ff;

    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            bvalid_ff <= 1'b0;
            bresp_ff  <= RESP_OKAY;
            ctrl_ff   <= CTRL_RST;
            delay_ff  <= DELAY_RST;
            imsk_ff   <= '0;
        end
        else
        begin
            if (bvalid_ff && s_axi_bready)
                bvalid_ff <= 1'b0;
            if (wr_go)
            begin
                bvalid_ff <= 1'b1;
                bresp_ff  <= RESP_OKAY;
                case (s_axi_awaddr)
                    ADDR_CTRL:
                        if (s_axi_wstrb[0])
                            ctrl_ff <= s_axi_wdata[2:0];
                    ADDR_DELAY:
                    begin
                        if (s_axi_wstrb[0])
                            delay_ff[7:0] <= s_axi_wdata[7:0];
                        if (s_axi_wstrb[1])
                            delay_ff[15:8] <= s_axi_wdata[15:8];
                    end
                    ADDR_IMSK:
                        if (s_axi_wstrb[0])
                            imsk_ff <= s_axi_wdata[IRQ_W-1:0];
                    ADDR_STAT, ADDR_ISTS: ;
                    default:
                        bresp_ff <= RESP_SLVERR;
                endcase
            end
        end
    end

    // ------------------------------------------------------------
    // Interrupt status, set wins over clear
    // ------------------------------------------------------------
    always_comb
    begin
        ev           = '0;
        ev[IRQ_ACT]  = nxt_st == ST_ACT && st_ff != ST_ACT;
        ev[IRQ_REL]  = contacts_ff && !((nxt_st == ST_ACT || nxt_st == ST_REL) && !bk_force);
        ev[IRQ_FLT]  = relay_readback != {2{contacts_ff}} && chk_ff >= 32'(CHK_MS)
                       && supply_present && !relay_flt_ff;
        ev[IRQ_TRIP] = nxt_st == ST_TRIP && st_ff != ST_TRIP;
    end

    always_ff @(posedge clk)
    begin
        if (sys_rst)
            ists_ff <= '0;
        else if (wr_go && s_axi_awaddr == ADDR_ISTS && s_axi_wstrb[0])
            ists_ff <= (ists_ff & ~s_axi_wdata[IRQ_W-1:0]) | ev;
        else
            ists_ff <= ists_ff | ev;
    end

    assign irq = |(ists_ff & imsk_ff);

    // ------------------------------------------------------------
    // Register read channel
    // ------------------------------------------------------------
    assign s_axi_arready = ~rvalid_ff;
    assign s_axi_rvalid  = rvalid_ff;
    assign s_axi_rdata   = rdata_ff;
    assign s_axi_rresp   = rresp_ff;

    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            rvalid_ff <= 1'b0;
            rdata_ff  <= '0;
            rresp_ff  <= RESP_OKAY;
        end
        else if (rvalid_ff)
        begin
            if (s_axi_rready)
                rvalid_ff <= 1'b0;
        end
        else if (s_axi_arvalid)
        begin
            rvalid_ff <= 1'b1;
            rresp_ff  <= RESP_OKAY;
            rdata_ff  <= '0;
            case (s_axi_araddr)
                ADDR_CTRL:  rdata_ff <= {29'h0, ctrl_ff};
                ADDR_DELAY: rdata_ff <= {16'h0, delay_ff};
                ADDR_STAT:  rdata_ff <= {24'h0, go, relay_flt_ff, trip_ff,
                                         aux_ff, contacts_ff, st_ff};
                ADDR_ISTS:  rdata_ff <= {28'h0, ists_ff};
                ADDR_IMSK:  rdata_ff <= {28'h0, imsk_ff};
                default:    rresp_ff <= RESP_SLVERR;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    a_supply_lamp: assert property (@(posedge clk) disable iff (sys_rst) // R1
        supply_lamp == supply_present)
        else $error("supply lamp does not follow supply");
    a_ready_start: assert property (@(posedge clk) disable iff (sys_rst) // R2
        (st_ff == ST_OFF && nxt_st == ST_SWON) |-> start_loop_terminals)
        else $error("switch-on began without start loop");
    a_active_outs: assert property (@(posedge clk) disable iff (sys_rst) // R3
        (st_ff == ST_ACT && delay_ff != 16'h0000) |-> on_lamp && safety_contacts == 4'hF)
        else $error("active outputs wrong");
    a_aux_drop: assert property (@(posedge clk) disable iff (sys_rst) // R4
        (st_ff == ST_ACT && !in_ok) |=> !aux_indicator_output && !on_lamp)
        else $error("aux output not dropped at input open");
    a_release_hold: assert property (@(posedge clk) disable iff (sys_rst) // R5
        (st_ff == ST_REL && $past(st_ff) == ST_REL && !bk_force
         && tmr_ff < 32'(delay_ff) && supply_present) |-> contacts_ff)
        else $error("contacts opened before delay");
    a_backup_open: assert property (@(posedge clk) disable iff (sys_rst) // R6
        bk_force |=> !contacts_ff)
        else $error("contacts not forced open at twice delay");
    a_earth_block: assert property (@(posedge clk) disable iff (sys_rst) // R7
        earth_fault_sense |=> st_ff != ST_ACT && st_ff != ST_SWON ##1 !aux_ff)
        else $error("stayed active with earth fault");
    a_dual_short: assert property (@(posedge clk) disable iff (sys_rst) // R8
        (dual && input_short_sense) |=> st_ff != ST_ACT && st_ff != ST_SWON)
        else $error("input short not detected");
    a_cross_trip: assert property (@(posedge clk) disable iff (sys_rst) // R11
        (st_ff == ST_ACT && dual && bridged) |=> st_ff == ST_TRIP && trip_ff ##1 !contacts_ff)
        else $error("cross short did not trip");
    a_no_delay: assert property (@(posedge clk) disable iff (sys_rst) // R13
        (st_ff == ST_ACT && ctrl_ff[CTRL_NODLY] && !in_ok && !bridged) |=> !contacts_ff)
        else $error("contacts not opened at once without delay");
    a_relay_block: assert property (@(posedge clk) disable iff (sys_rst) // R14
        (relay_flt_ff && st_ff == ST_OFF) |=> st_ff == ST_OFF)
        else $error("relay fault does not block");
    a_swon_delay: assert property (@(posedge clk) disable iff (sys_rst) // R15
        (st_ff == ST_SWON && nxt_st == ST_ACT) |-> tmr_ff >= 32'(SWON_MS))
        else $error("closed before switch-on delay");

    c_activate: cover property (@(posedge clk) disable iff (sys_rst)
        st_ff == ST_SWON ##1 st_ff == ST_ACT);
    c_delayed_release: cover property (@(posedge clk) disable iff (sys_rst)
        st_ff == ST_REL ##1 st_ff == ST_RECV);
    c_trip: cover property (@(posedge clk) disable iff (sys_rst)
        st_ff == ST_ACT ##1 st_ff == ST_TRIP);
endmodule

// ### test/srdr_relay_bench.sv
// Self-checking bench for the delayed-release safety relay controller.
// Assumes srdr_relay and srdr_switches; one clock, timers scaled by TK.
`timescale 1ns/1ps
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin miscompares++; \
    $display("BAD t=%0t got=%h exp=%h", $time, (g), (e)); end end
module srdr_relay_bench
    import srdr_pkg::*;
;
    localparam int TK = 4;
    localparam int FT = 3;
    logic        clk = 1'b0, sys_rst = 1'b1, supply_present = 1'b1;
    logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
    logic [31:0] s_axi_wdata = 32'h00000000, s_axi_rdata;
    logic [3:0]  s_axi_wstrb = 4'hF, safety_contacts;
    logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0]  s_axi_bresp, s_axi_rresp, relay_readback;
    logic        want_in = 1'b0, want_start = 1'b1, want_bridge = 1'b0;
    logic        want_earth = 1'b0, want_short = 1'b0, want_stuck = 1'b0;
    logic        input_ch1, input_ch2, start_loop_terminals, earth_fault_sense;
    logic        cross_test_terminal_a, cross_test_terminal_b, input_short_sense;
    logic        supply_lamp, first_channel_lamp, second_channel_lamp;
    logic        aux_indicator_output, on_lamp, irq;
    logic [65:0] eq[$];
    logic [1:0]  bq[$];
    logic [65:0] e;
    logic [31:0] seed = 32'h000012D7;
    int          miscompares = 0, num_checks = 0, d;
    always #2 clk = ~clk;
    srdr_relay #(.TICK_CYCLES(TK), .FUSE_TICKS(FT)) dut (.clk, .sys_rst,
        .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
        .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready, .supply_present, .start_loop_terminals, .input_ch1,
        .input_ch2, .earth_fault_sense, .input_short_sense, .cross_test_terminal_a,
        .cross_test_terminal_b, .relay_readback, .supply_lamp, .first_channel_lamp,
        .second_channel_lamp, .safety_contacts, .aux_indicator_output, .on_lamp, .irq);
    srdr_switches sw (.clk, .want_in, .want_start, .want_bridge, .want_earth,
        .want_short, .want_stuck, .contacts(safety_contacts), .input_ch1, .input_ch2,
        .start_loop_terminals, .cross_test_terminal_a, .cross_test_terminal_b,
        .earth_fault_sense, .input_short_sense, .relay_readback);
    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] t;
        t = s ^ (s << 13);
        t = t ^ (t >> 17);
        return t ^ (t << 5);
    endfunction
    task automatic wr(input logic [11:0] a, input logic [31:0] v, input logic [1:0] r);
        bq.push_back(r);
        s_axi_awaddr  <= a;
        s_axi_wdata   <= v;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid  <= 1'b1;
        s_axi_bready  <= 1'b1;
        do @(posedge clk); while (!s_axi_awready);
        s_axi_awvalid <= 1'b0;
        s_axi_wvalid  <= 1'b0;
        do @(posedge clk); while (!s_axi_bvalid);
        s_axi_bready <= 1'b0;
        @(posedge clk);
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] v, m, input logic [1:0] r);
        eq.push_back({m, v, r});
        s_axi_araddr  <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready  <= 1'b1;
        do @(posedge clk); while (!s_axi_arready);
        s_axi_arvalid <= 1'b0;
        do @(posedge clk); while (!s_axi_rvalid);
        s_axi_rready <= 1'b0;
        @(posedge clk);
    endtask
    task automatic wait_ct(input logic [3:0] v, input int lim);
        int n;
        n = 0;
        while (safety_contacts !== v && n < lim)
        begin
            @(posedge clk);
            n++;
        end
        `CHK(safety_contacts, v)
    endtask
    task automatic act();
        want_in    <= 1'b1;
        want_start <= 1'b1;
        repeat (45 * TK) @(posedge clk);
        `CHK(safety_contacts, 4'h0)
        wait_ct(4'hF, 10 * TK);
    endtask
    task automatic rel(input int lim);
        want_in <= 1'b0;
        wait_ct(4'h0, lim);
        repeat (310 * TK) @(posedge clk);
    endtask
    task automatic summarize();
        $display("checks=%0d miscompares=%0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    // ------------------------------------------------------------
    // Response monitor
    // ------------------------------------------------------------
    always @(posedge clk)
    begin
        if (s_axi_rvalid && s_axi_rready && eq.size() > 0)
        begin
            e = eq.pop_front();
            `CHK(s_axi_rdata & e[65:34], e[33:2])
            `CHK(s_axi_rresp, e[1:0])
        end
        if (s_axi_bvalid && s_axi_bready && bq.size() > 0)
            `CHK(s_axi_bresp, bq[0])
        if (s_axi_bvalid && s_axi_bready && bq.size() > 0)
            bq.pop_front();
    end
    initial
    begin
        repeat (60000) @(posedge clk);
        miscompares++;
        summarize();
    end
    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    initial
    begin
        repeat (6) @(posedge clk);
        sys_rst <= 1'b0;
        @(posedge clk);
        `CHK(supply_lamp, 1'b1)
        rd(ADDR_CTRL, 32'h1, 32'h7, RESP_OKAY);
        rd(ADDR_DELAY, 32'h3E8, 32'hFFFF, RESP_OKAY);
        rd(ADDR_IMSK, 32'h0, 32'hF, RESP_OKAY);
        rd(12'h020, 32'h0, 32'hFFFFFFFF, RESP_SLVERR);
        wr(12'h020, 32'h1, RESP_SLVERR);
        wr(ADDR_STAT, 32'hFF, RESP_OKAY);
        rd(ADDR_STAT, 32'h0, 32'h7F, RESP_OKAY);
        seed = xs(seed);
        wr(ADDR_DELAY, {16'h0000, seed[15:0]}, RESP_OKAY);
        rd(ADDR_DELAY, {16'h0000, seed[15:0]}, 32'hFFFF, RESP_OKAY);
        seed = xs(seed);
        d = 4 + int'(seed[2:0]);
        wr(ADDR_DELAY, 32'(d), RESP_OKAY);
        act();
        `CHK({first_channel_lamp, second_channel_lamp, aux_indicator_output}, 3'h7)
        `CHK(on_lamp, 1'b1)
        `CHK(irq, 1'b0)
        rd(ADDR_STAT, 32'h1A, 32'h1F, RESP_OKAY);
        wr(ADDR_IMSK, 32'h1, RESP_OKAY);
        `CHK(irq, 1'b1)
        wr(ADDR_ISTS, 32'h1, RESP_OKAY);
        `CHK(irq, 1'b0)
        want_in <= 1'b0;
        repeat (3) @(posedge clk);
        `CHK({aux_indicator_output, on_lamp}, 2'h0)
        `CHK(safety_contacts, 4'hF)
        repeat ((d - 1) * TK - 5) @(posedge clk);
        `CHK(safety_contacts, 4'hF)
        rel(4 * TK + 4);
        `CHK({first_channel_lamp, second_channel_lamp}, 2'h0)
        wr(ADDR_CTRL, 32'h5, RESP_OKAY);
        act();
        rel(4);
        wr(ADDR_CTRL, 32'h3, RESP_OKAY);
        want_start <= 1'b0;
        want_in    <= 1'b1;
        repeat (300) @(posedge clk);
        `CHK(safety_contacts, 4'h0)
        rd(ADDR_STAT, 32'h0, 32'h80, RESP_OKAY);
        act();
        rel(d * TK + 20);
        wr(ADDR_CTRL, 32'h0, RESP_OKAY);
        want_earth <= 1'b1;
        want_in    <= 1'b1;
        repeat (300) @(posedge clk);
        `CHK(safety_contacts, 4'h0)
        want_earth <= 1'b0;
        want_in    <= 1'b0;
        wr(ADDR_CTRL, 32'h1, RESP_OKAY);
        want_short <= 1'b1;
        want_in    <= 1'b1;
        repeat (300) @(posedge clk);
        `CHK(safety_contacts, 4'h0)
        want_short <= 1'b0;
        want_in    <= 1'b0;
        @(posedge clk);
        act();
        want_bridge <= 1'b1;
        wait_ct(4'h0, 8);
        rd(ADDR_STAT, 32'h20, 32'h20, RESP_OKAY);
        want_bridge    <= 1'b0;
        supply_present <= 1'b0;
        repeat (2) @(posedge clk);
        `CHK(supply_lamp, 1'b0)
        repeat ((FT + 2) * TK) @(posedge clk);
        supply_present <= 1'b1;
        @(posedge clk);
        rd(ADDR_STAT, 32'h0, 32'h20, RESP_OKAY);
        want_in <= 1'b0;
        @(posedge clk);
        act();
        want_stuck <= 1'b1;
        repeat (25 * TK + 8) @(posedge clk);
        rd(ADDR_STAT, 32'h40, 32'h40, RESP_OKAY);
        wr(ADDR_IMSK, 32'h4, RESP_OKAY);
        `CHK(irq, 1'b1)
        rel(d * TK + 20);
        want_in <= 1'b1;
        repeat (300) @(posedge clk);
        `CHK(safety_contacts, 4'h0)
        summarize();
    end
endmodule

// ### test/srdr_switches.sv
// Operator side model: input switches, start loop, cross-test terminals, relay readback.
// Assumes bench commands change just after a rising edge of clk.
`timescale 1ns/1ps
module srdr_switches
(
    input  wire logic       clk,
    input  wire logic       want_in,
    input  wire logic       want_start,
    input  wire logic       want_bridge,
    input  wire logic       want_earth,
    input  wire logic       want_short,
    input  wire logic       want_stuck,
    input  wire logic [3:0] contacts,
    output logic            input_ch1,
    output logic            input_ch2,
    output logic            start_loop_terminals,
    output logic            cross_test_terminal_a,
    output logic            cross_test_terminal_b,
    output logic            earth_fault_sense,
    output logic            input_short_sense,
    output logic [1:0]      relay_readback
);
    // ------------------------------------------------------------
    // Test pulses and relay armature lag
    // ------------------------------------------------------------
    logic       pulse_ff = 1'b0;
    logic [1:0] arm1_ff  = 2'h0;
    logic [1:0] arm2_ff  = 2'h0;
    always_ff @(posedge clk) pulse_ff <= ~pulse_ff;
    always_ff @(posedge clk) arm1_ff <= contacts[1:0];
    always_ff @(posedge clk) arm2_ff <= arm1_ff;
    assign cross_test_terminal_a = want_bridge | pulse_ff;
    assign cross_test_terminal_b = want_bridge | ~pulse_ff;
    assign input_ch1             = want_in;
    assign input_ch2             = want_in;
    assign start_loop_terminals  = want_start;
    assign earth_fault_sense     = want_earth;
    assign input_short_sense     = want_short;
    assign relay_readback        = want_stuck ? 2'h0 : arm2_ff;
endmodule
